/* rtl/iam_mapper.sv */
// Indirect access mapper: pointers, region sequencer and APB registers
// Operation
// - Indirect port accesses go where pointer selects
// - Pointer at indirect port: read 0, no write
// - Pointer is high byte above low byte
// - Sixteen-bit pointer split into three regions
// - 0x000-0xFFF reaches same absolute data address
// - 0x2000-0x29AF is the linear RAM window
// - Each bank adds 80 bytes, back to back
// - Unbacked locations read as 0x00
// - Common memory never appears in linear window
// - Pointer MSb set selects flash word address
// - Flash read yields low eight bits only
// - Writes to flash have no effect
// - Flash access costs one extra cycle
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module iam_mapper #(
   parameter int PTR_COUNT = 2,
   parameter int FLASH_W = 14
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Core side indirect access port
   input wire logic acc_req_i,
   input wire logic acc_sel_i,
   input wire logic acc_we_i,
   input wire logic [7:0] acc_wdata_i,
   output logic acc_busy_o,
   output logic acc_done_o,
   output logic [7:0] acc_rdata_o,
   output logic acc_self_o,
   // Data memory port
   output logic dm_req_o,
   output logic dm_we_o,
   output logic [11:0] dm_addr_o,
   output logic [7:0] dm_wdata_o,
   input wire logic [7:0] dm_rdata_i,
   // Program flash read port
   output logic pf_req_o,
   output logic [14:0] pf_addr_o,
   input wire logic [FLASH_W-1:0] pf_rdata_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [PTR_COUNT-1:0][7:0] ptr_lo;
      logic [PTR_COUNT-1:0][7:0] ptr_hi;
      iam_pkg::iam_state_e st;
      iam_pkg::iam_region_e region;
      logic busy;
      logic done;
      logic self_hit;
      logic [7:0] rdata;
      logic dm_req;
      logic dm_we;
      logic [11:0] dm_addr;
      logic [7:0] dm_wdata;
      logic pf_req;
      logic [14:0] pf_addr;
      logic [7:0] fcnt;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } iam_state_s;

   iam_state_s s_r;
   iam_state_s s_nxt;

   iam_xlat_if xl ();

   iam_xlat u_xlat (
      .x(xl.xlat)
   );

   // ==========================================================
   // Helpers
   function automatic logic [15:0] ptr_of(input iam_state_s s,
                                          input logic sel);
      ptr_of = {s.ptr_hi[sel], s.ptr_lo[sel]};
   endfunction

   function automatic logic apb_known(input logic [7:0] a);
      apb_known = (a == iam_pkg::OFS_PTR0_LO) ||
                  (a == iam_pkg::OFS_PTR0_HI) ||
                  (a == iam_pkg::OFS_PTR1_LO) ||
                  (a == iam_pkg::OFS_PTR1_HI) ||
                  (a == iam_pkg::OFS_STATUS);
   endfunction

   assign xl.ptr = ptr_of(s_r, acc_sel_i);

   // ==========================================================
   // Next state
   always_comb begin
      logic [31:0] rd;
      logic wr_go;
      rd = 32'h0000_0000;
      wr_go = 1'b0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.dm_req = 1'b0;
      s_nxt.dm_we = 1'b0;
      s_nxt.pf_req = 1'b0;

      // Indirect access sequencer; requests while busy are dropped
      unique case (s_r.st)
         iam_pkg::ST_IDLE: begin
            if (acc_req_i) begin
               s_nxt.st = iam_pkg::ST_ISSUE;
               s_nxt.busy = 1'b1;
               s_nxt.region = xl.region;
               s_nxt.self_hit = 1'b0;
               s_nxt.rdata = iam_pkg::ZERO_BYTE;
               s_nxt.dm_addr = xl.dm_addr;
               s_nxt.dm_wdata = acc_wdata_i;
               s_nxt.pf_addr = xl.pf_addr;
               unique case (xl.region)
                  iam_pkg::RGN_TRAD, iam_pkg::RGN_LIN: begin
                     s_nxt.dm_req = 1'b1;
                     s_nxt.dm_we = acc_we_i;
                  end
                  iam_pkg::RGN_FLASH: begin
                     s_nxt.pf_req = !acc_we_i;
                     s_nxt.fcnt = s_r.fcnt + 8'h01;
                  end
                  iam_pkg::RGN_SELF: begin
                     // Flags may still change; data path sees 0
                     s_nxt.self_hit = 1'b1;
                  end
                  default: begin
                     // Nothing behind it: no strobe issued
                     s_nxt.dm_req = 1'b0;
                  end
               endcase
            end
         end
         iam_pkg::ST_ISSUE: begin
            if (s_r.region == iam_pkg::RGN_FLASH) begin
               s_nxt.st = iam_pkg::ST_FWAIT;
            end else begin
               s_nxt.st = iam_pkg::ST_MEM;
            end
         end
         iam_pkg::ST_MEM: begin
            s_nxt.st = iam_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            if (s_r.region == iam_pkg::RGN_TRAD ||
                s_r.region == iam_pkg::RGN_LIN) begin
               s_nxt.rdata = dm_rdata_i;
            end else begin
               s_nxt.rdata = iam_pkg::ZERO_BYTE;
            end
         end
         iam_pkg::ST_FWAIT: begin
            // Extra stage keeps flash timing one cycle longer
            s_nxt.st = iam_pkg::ST_FDONE;
            s_nxt.rdata = pf_rdata_i[7:0];
         end
         iam_pkg::ST_FDONE: begin
            s_nxt.st = iam_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
         default: begin
            s_nxt.st = iam_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
         end
      endcase

      // APB: one wait state, then the transfer completes
      if (psel_i && penable_i && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !apb_known(paddr_i);
         unique case (paddr_i)
            iam_pkg::OFS_PTR0_LO: rd[7:0] = s_r.ptr_lo[0];
            iam_pkg::OFS_PTR0_HI: rd[7:0] = s_r.ptr_hi[0];
            iam_pkg::OFS_PTR1_LO: rd[7:0] = s_r.ptr_lo[1];
            iam_pkg::OFS_PTR1_HI: rd[7:0] = s_r.ptr_hi[1];
            iam_pkg::OFS_STATUS: begin
               rd[iam_pkg::STAT_BUSY_BIT] = s_r.busy;
               rd[iam_pkg::STAT_REGION_LSB +: 3] = s_r.region;
               rd[iam_pkg::STAT_FCNT_LSB +: 8] = s_r.fcnt;
            end
            default: rd = 32'h0000_0000;
         endcase
         s_nxt.prdata = rd;
      end else if (psel_i && penable_i && s_r.pready) begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
         wr_go = pwrite_i && pstrb_i[0];
      end else begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
      end

      if (wr_go) begin
         unique case (paddr_i)
            iam_pkg::OFS_PTR0_LO: s_nxt.ptr_lo[0] = pwdata_i[7:0];
            iam_pkg::OFS_PTR0_HI: s_nxt.ptr_hi[0] = pwdata_i[7:0];
            iam_pkg::OFS_PTR1_LO: s_nxt.ptr_lo[1] = pwdata_i[7:0];
            iam_pkg::OFS_PTR1_HI: s_nxt.ptr_hi[1] = pwdata_i[7:0];
            default: s_nxt.fcnt = s_nxt.fcnt;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
         s_r.st <= iam_pkg::ST_IDLE;
         s_r.region <= iam_pkg::RGN_TRAD;
         for (int i = 0; i < PTR_COUNT; i++) begin
            s_r.ptr_lo[i] <= iam_pkg::PTR_RST;
            s_r.ptr_hi[i] <= iam_pkg::PTR_RST;
         end
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign acc_busy_o = s_r.busy;
   assign acc_done_o = s_r.done;
   assign acc_rdata_o = s_r.rdata;
   assign acc_self_o = s_r.self_hit;
   assign dm_req_o = s_r.dm_req;
   assign dm_we_o = s_r.dm_we;
   assign dm_addr_o = s_r.dm_addr;
   assign dm_wdata_o = s_r.dm_wdata;
   assign pf_req_o = s_r.pf_req;
   assign pf_addr_o = s_r.pf_addr;
   assign pready_o = s_r.pready;
   assign prdata_o = s_r.prdata;
   assign pslverr_o = s_r.pslverr;

endmodule

/* rtl/iam_pkg.sv */
// Constants and types shared by the indirect address mapper files
package iam_pkg;

   // ==========================================================
   // Pointer address map
   localparam logic [15:0] TRAD_LAST = 16'h0fff;
   localparam logic [15:0] LIN_FIRST = 16'h2000;
   localparam logic [15:0] LIN_LAST = 16'h29af;
   localparam int FLASH_SEL_BIT = 15;
   localparam logic [6:0] GPR_SIZE = 7'h50;
   localparam logic [6:0] GPR_BASE = 7'h20;
   localparam int BANK_SHIFT = 7;
   localparam logic [6:0] IND_LOC0 = 7'h00;
   localparam logic [6:0] IND_LOC1 = 7'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ==========================================================
   // APB register map
   localparam logic [7:0] OFS_PTR0_LO = 8'h00;
   localparam logic [7:0] OFS_PTR0_HI = 8'h04;
   localparam logic [7:0] OFS_PTR1_LO = 8'h08;
   localparam logic [7:0] OFS_PTR1_HI = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_REGION_LSB = 1;
   localparam int STAT_FCNT_LSB = 8;

   // ==========================================================
   // Regions and sequencer states
   typedef enum logic [2:0] {
      RGN_TRAD = 3'b000,
      RGN_LIN = 3'b001,
      RGN_FLASH = 3'b010,
      RGN_NONE = 3'b011,
      RGN_SELF = 3'b100
   } iam_region_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ISSUE = 3'b001,
      ST_MEM = 3'b010,
      ST_FWAIT = 3'b011,
      ST_FDONE = 3'b100
   } iam_state_e;

endpackage

/* rtl/iam_xlat.sv */
// Pointer to region and physical address translation
`timescale 1ns/1ps
module iam_xlat (
   iam_xlat_if.xlat x
);

   // ==========================================================
   // Linear window to banked address
   function automatic logic [11:0] lin_to_abs(input logic [15:0] p);
      logic [11:0] ofs;
      logic [11:0] bank;
      logic [11:0] rem;
      ofs = 12'(p - iam_pkg::LIN_FIRST);
      bank = ofs / 12'(iam_pkg::GPR_SIZE);
      rem = ofs % 12'(iam_pkg::GPR_SIZE);
      lin_to_abs = 12'(bank << iam_pkg::BANK_SHIFT)
                   + 12'(iam_pkg::GPR_BASE) + rem;
   endfunction

   // ==========================================================
   // Region decode
   always_comb begin
      x.dm_addr = x.ptr[11:0];
      x.pf_addr = x.ptr[14:0];
      if (x.ptr[iam_pkg::FLASH_SEL_BIT]) begin
         x.region = iam_pkg::RGN_FLASH;
      end else if (x.ptr <= iam_pkg::TRAD_LAST) begin
         if (x.ptr[6:0] == iam_pkg::IND_LOC0 ||
             x.ptr[6:0] == iam_pkg::IND_LOC1) begin
            x.region = iam_pkg::RGN_SELF;
         end else begin
            x.region = iam_pkg::RGN_TRAD;
         end
      end else if (x.ptr >= iam_pkg::LIN_FIRST &&
                   x.ptr <= iam_pkg::LIN_LAST) begin
         x.region = iam_pkg::RGN_LIN;
         x.dm_addr = lin_to_abs(x.ptr);
      end else begin
         x.region = iam_pkg::RGN_NONE;
      end
   end

endmodule

/* rtl/iam_xlat_if.sv */
// Carrier between the mapper top and its address translator
`timescale 1ns/1ps
interface iam_xlat_if;
   logic [15:0] ptr;
   iam_pkg::iam_region_e region;
   logic [11:0] dm_addr;
   logic [14:0] pf_addr;

   modport xlat (input ptr, output region, dm_addr, pf_addr);
   modport user (output ptr, input region, dm_addr, pf_addr);
endinterface

/* tb/iam_mapper_asserts.sv */
// Port assertions for the indirect address mapper
`timescale 1ns/1ps
module iam_mapper_asserts #(
   parameter int FLASH_W = 14
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic acc_busy_o,
   input wire logic acc_done_o,
   input wire logic [7:0] acc_rdata_o,
   input wire logic acc_self_o,
   input wire logic dm_req_o,
   input wire logic dm_we_o,
   input wire logic [7:0] dm_rdata_i,
   input wire logic pf_req_o,
   input wire logic [FLASH_W-1:0] pf_rdata_i
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // ===================
   // Checks
   sequence s_dm_rd;
      dm_req_o && !dm_we_o;
   endsequence
   sequence s_fl;
      pf_req_o;
   endsequence
   a_dm_data: assert property (s_dm_rd |-> ##2 acc_done_o
      && acc_rdata_o == $past(dm_rdata_i)) else $error("dm read bad");
   a_dm_single: assert property (dm_req_o |=> !dm_req_o)
      else $error("dm strobe long");
   a_fl_late: assert property (s_fl |->
      !acc_done_o[*3] ##1 acc_done_o) else $error("flash timing bad");
   a_fl_byte: assert property (s_fl |-> ##3
      acc_rdata_o == $past(pf_rdata_i[7:0], 2)) else $error("flash byte bad");
   a_fl_nodm: assert property (s_fl |-> !dm_req_o[*4])
      else $error("dm strobe in flash access");
   a_self_zero: assert property (acc_done_o && acc_self_o
      |-> acc_rdata_o == 8'h00) else $error("self read not zero");
   a_done_one: assert property (acc_done_o |=> !acc_done_o)
      else $error("done long");
   a_busy_span: assert property ($rose(acc_busy_o) |->
      acc_busy_o[*2] ##[1:2] (acc_done_o && !acc_busy_o))
      else $error("busy span bad");
endmodule
bind iam_mapper iam_mapper_asserts #(.FLASH_W(FLASH_W)) u_chk (.*);

/* tb/iam_mem_model.sv */
// Data memory and program flash model facing the mapper
`timescale 1ns/1ps
module iam_mem_model #(
   parameter int FLASH_W = 14
) (
   input wire logic clk_sys_i,
   input wire logic dm_req_i,
   input wire logic dm_we_i,
   input wire logic [11:0] dm_addr_i,
   input wire logic [7:0] dm_wdata_i,
   output logic [7:0] dm_rdata_o,
   input wire logic pf_req_i,
   input wire logic [14:0] pf_addr_i,
   output logic [FLASH_W-1:0] pf_rdata_o
);
   logic [7:0] mem [4096];
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0] ^ 8'h5a;
      end
      dm_rdata_o = 8'h00;
      pf_rdata_o = '0;
   end
   // ===================
   // Idle lines toggle so stale data never passes
   always @(posedge clk_sys_i) begin
      if (dm_req_i && dm_we_i) begin
         mem[dm_addr_i] <= dm_wdata_i;
      end
      dm_rdata_o <= (dm_req_i && !dm_we_i) ? mem[dm_addr_i] : ~dm_rdata_o;
      pf_rdata_o <= pf_req_i ? FLASH_W'({pf_addr_i[7:0], ~pf_addr_i[7:0]})
         : ~pf_rdata_o;
   end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the indirect address mapper
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, sel = 1'b0, we = 1'b0;
   logic busy, done, self, dreq, dwe, preq, prdy, perr;
   logic [7:0] wd = 8'h00, rdat, dwd, drd, pa = 8'h00;
   logic [11:0] dad;
   logic [14:0] pad;
   logic [13:0] prd;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [3:0] pst = 4'h0;
   logic [31:0] pwd = 32'h0, prda;
   int err_total = 0, check_count = 0, ndm = 0, npf = 0;
   iam_mapper DUT (.clk_sys_i(clk), .sys_rst_i(rst), .ce_i(1'b1),
      .acc_req_i(req), .acc_sel_i(sel), .acc_we_i(we), .acc_wdata_i(wd),
      .acc_busy_o(busy), .acc_done_o(done), .acc_rdata_o(rdat),
      .acc_self_o(self), .dm_req_o(dreq), .dm_we_o(dwe), .dm_addr_o(dad),
      .dm_wdata_o(dwd), .dm_rdata_i(drd), .pf_req_o(preq), .pf_addr_o(pad),
      .pf_rdata_i(prd), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .pready_o(prdy),
      .prdata_o(prda), .pslverr_o(perr));
   iam_mem_model u_mem (.clk_sys_i(clk), .dm_req_i(dreq), .dm_we_i(dwe),
      .dm_addr_i(dad), .dm_wdata_i(dwd), .dm_rdata_o(drd),
      .pf_req_i(preq), .pf_addr_i(pad), .pf_rdata_o(prd));
   initial begin
      forever #4 clk = ~clk;
   end
   // Strobes counted mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      if (dreq === 1'b1) ndm <= ndm + 1;
      if (preq === 1'b1) npf <= npf + 1;
   end
   // ===================
   // Shared tasks
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      pst <= 4'h1;
      @(posedge clk);
      pen <= 1'b1;
      // Look mid-cycle so the edge that launches pready is never raced
      for (n = 0; n < 20; n++) begin
         @(negedge clk);
         if (prdy === 1'b1) break;
      end
      if (n == 20) begin
         err_total++;
         test_done();
      end
      r = prda;
      e = perr;
      // Hold the request through the edge that samples pready high
      @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic setp(input logic s, input logic [15:0] p);
      logic [31:0] r;
      logic e;
      apb(1'b1, s ? 8'h08 : 8'h00, {24'h0, p[7:0]}, r, e);
      apb(1'b1, s ? 8'h0c : 8'h04, {24'h0, p[15:8]}, r, e);
   endtask
   // Sets pointer, runs one access, checks timing, strobes and read data
   task automatic probe(input logic s, input logic [15:0] p, input logic w,
         input logic [7:0] e, input int el, input int edm, input int epf);
      int lat, d0, f0;
      setp(s, p);
      d0 = ndm;
      f0 = npf;
      req <= 1'b1;
      sel <= s;
      we <= w;
      wd <= e;
      @(posedge clk);
      req <= 1'b0;
      for (lat = 1; lat < 10; lat++) begin
         @(negedge clk);
         if (done === 1'b1) break;
      end
      if (lat == 10) begin
         err_total++;
         test_done();
      end
      chk(lat, el);
      chk(ndm - d0, edm);
      chk(npf - f0, epf);
      if (!w) chk(rdat, e);
      // Back onto the rising edge before the next request
      @(posedge clk);
   endtask
   // ===================
   // Scenarios
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, 8'h04, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b1, 8'h0c, 32'ha5, r, e);
      apb(1'b0, 8'h0c, 32'h0, r, e);
      chk(r, 32'ha5);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk(e, 1'b1);
   endtask
   task automatic t_trad;
      probe(1'b0, 16'h0123, 1'b0, 8'h79, 3, 1, 0);
      chk(dad, 12'h123);
      probe(1'b1, 16'h0fff, 1'b1, 8'hc3, 3, 1, 0);
      probe(1'b0, 16'h0fff, 1'b0, 8'hc3, 3, 1, 0);
   endtask
   task automatic t_lin;
      logic [15:0] pl [4] = '{16'h2000, 16'h204f, 16'h2050, 16'h29af};
      logic [11:0] a;
      foreach (pl[i]) begin
         a = 12'((pl[i] - 16'h2000) / 80 * 128 + 32 + (pl[i] - 16'h2000) % 80);
         probe(1'b0, pl[i], 1'b0, a[7:0] ^ 8'h5a, 3, 1, 0);
         chk(dad, a);
      end
   endtask
   task automatic t_gap;
      probe(1'b0, 16'h1000, 1'b0, 8'h00, 3, 0, 0);
      probe(1'b1, 16'h29b0, 1'b0, 8'h00, 3, 0, 0);
      probe(1'b0, 16'h7fff, 1'b1, 8'h77, 3, 0, 0);
   endtask
   task automatic t_self;
      probe(1'b0, 16'h0001, 1'b0, 8'h00, 3, 0, 0);
      chk(self, 1'b1);
      probe(1'b1, 16'h0080, 1'b1, 8'h99, 3, 0, 0);
   endtask
   task automatic t_flash;
      logic [31:0] r;
      logic e;
      probe(1'b0, 16'h8005, 1'b0, 8'hfa, 4, 0, 1);
      chk(pad, 15'h0005);
      probe(1'b1, 16'hff80, 1'b0, 8'h7f, 4, 0, 1);
      chk(pad, 15'h7f80);
      probe(1'b0, 16'hffff, 1'b1, 8'h12, 4, 0, 0);
      // Status: idle, last region flash, three flash accesses
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk(r, 32'h0000_0304);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_trad();
      t_lin();
      t_gap();
      t_self();
      t_flash();
      test_done();
   end
endmodule
